/* core/trb_timer.v */
// Reload timer with event counting, buzzer toggle and PWM output, on an APB slave.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "trb_regs.vh"
//
// Summary of operation
// - With autoload set and PWM off, an overflow copies the reload value into the count.
// - Reload value is a write-only 8-bit register, zero after reset.
// - Boundary 256, or with PWM on and internal clock 256/64/32/16.
// - Toggle output flips the pin each overflow and takes over the pin.
// - Clearing the run bit stops counting, toggle output and PWM.
// - Count leaving 0xFF sets the overflow flag, running or not.
// - PWM output is high while count is below reload, else low.
// - PWM output is forced high when the counter wraps to zero.
// - Duty is reload over modulus, values kept below the modulus.
// - PWM select drives the PWM waveform onto the shared pin.
// - In PWM mode each wrap sets the overflow flag.
// - Prescale codes 000 to 111 divide by 256 down to 2.
// - External source counts falling event edges and masks the event irq.
module trb_timer (
    input wire mclk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_event_input,
    output wire ext_event_irq_block,
    output reg shared_output_pin,
    output wire shared_output_pin_oe,
    output wire irq
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [7:0] timer_mode_reg;
    reg [7:0] count_value_reg;
    reg [7:0] reload_value_reg;
    reg overflow_irq_flag;
    reg overflow_irq_enable;
    reg toggle_state;
    reg [2:0] event_sync;

    // ****************************************************************
    // Mode register fields
    // ****************************************************************
    wire pwm_out_select = timer_mode_reg[`TRB_PWM_BIT];
    wire toggle_out_select = timer_mode_reg[`TRB_TOGGLE_BIT];
    wire autoload_select = timer_mode_reg[`TRB_ALOAD_BIT];
    wire clock_source_select = timer_mode_reg[`TRB_CKS_BIT];
    wire [2:0] prescale_select = timer_mode_reg[`TRB_RATE_MSB:`TRB_RATE_LSB];
    wire counter_run = timer_mode_reg[`TRB_RUN_BIT];

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // The slave never waits, so every access completes in its first access cycle.
    assign pready = 1'b1;

    // Indexed registers sit at four times their index, so the low address bits are zero.
    function hit_index;
        input [11:0] addr;
        input [11:0] idx;
        begin
            hit_index = (addr == {idx[9:0], 2'b00});
        end
    endfunction

    // Status and mask are placed by their byte address.
    function hit_byte;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit_byte = (addr == ofs);
        end
    endfunction

    wire sel_mode = hit_index(paddr, `TRB_MODE_OFS);
    wire sel_count = hit_index(paddr, `TRB_COUNT_OFS);
    wire sel_reload = hit_index(paddr, `TRB_RELOAD_OFS);
    wire sel_stat = hit_byte(paddr, `TRB_IRQ_STAT_OFS);
    wire sel_mask = hit_byte(paddr, `TRB_IRQ_MASK_OFS);
    wire mapped = sel_mode || sel_count || sel_reload || sel_stat || sel_mask;
    wire access = psel && penable;
    wire rd_setup = psel && !penable && !pwrite;
    assign pslverr = access && !mapped;

    // ****************************************************************
    // Register write strobes
    // ****************************************************************
    wire wr = access && pwrite;
    wire wr_mode = wr && sel_mode;
    wire wr_count = wr && sel_count;
    wire wr_reload = wr && sel_reload;
    wire wr_stat = wr && sel_stat;
    wire wr_mask = wr && sel_mask;

    // ****************************************************************
    // Read data
    // ****************************************************************
    reg [31:0] next_prdata;

    // The word is captured in the setup cycle so that it stands through the access.
    always @* begin
        next_prdata = 32'h00000000;
        if (sel_mode) begin
            next_prdata = {24'h000000, timer_mode_reg};
        end else if (sel_count) begin
            next_prdata = {24'h000000, count_value_reg};
        end else if (sel_stat) begin
            next_prdata = {31'h00000000, overflow_irq_flag};
        end else if (sel_mask) begin
            next_prdata = {31'h00000000, overflow_irq_enable};
        end
        // The reload register is write-only and reads as zero, as do unmapped words.
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // ****************************************************************
    // Tick sources
    // ****************************************************************
    wire prescale_tick;

    // The prescaler restarts while stopped, so the first tick after a start is a full period.
    trb_prescaler u_prescaler (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(counter_run),
        .rate(prescale_select),
        .tick(prescale_tick)
    );

    // ****************************************************************
    // Event input synchroniser
    // ****************************************************************
    reg event_level;

    always @(posedge mclk) begin
        if (!reset_n) begin
            event_sync <= 3'b111;
        end else begin
            event_sync <= {event_sync[1:0], ext_event_input};
        end
    end

    // A new level counts once stages two and three agree, which rejects a single-sample
    // glitch; the level starts at the idle high, so no false fall follows reset.
    always @(posedge mclk) begin
        if (!reset_n) begin
            event_level <= 1'b1;
        end else if (event_sync[2:1] == 2'b00) begin
            event_level <= 1'b0;
        end else if (event_sync[2:1] == 2'b11) begin
            event_level <= 1'b1;
        end
    end

    wire event_fall = event_level && (event_sync[2:1] == 2'b00);
    assign ext_event_irq_block = clock_source_select;
    wire tick = clock_source_select ? event_fall : prescale_tick;

    // ****************************************************************
    // Modulus select
    // ****************************************************************
    // PWM on the event clock keeps the full 256 count period.
    wire pwm_mode = pwm_out_select && !clock_source_select;

    // Top count of the selected modulus: 256, 64, 32 or 16 counts per period.
    function [7:0] modulus_top;
        input pwm;
        input [1:0] sel;
        begin
            modulus_top = 8'hff;
            if (pwm) begin
                case (sel)
                    2'b00: modulus_top = 8'hff;
                    2'b01: modulus_top = 8'h3f;
                    2'b10: modulus_top = 8'h1f;
                    2'b11: modulus_top = 8'h0f;
                    default: modulus_top = 8'hff;
                endcase
            end
        end
    endfunction

    wire [7:0] modulus_mask = modulus_top(pwm_mode, {autoload_select, toggle_out_select});

    // ****************************************************************
    // Counter
    // ****************************************************************
    wire step = counter_run && tick;
    wire at_top = ((count_value_reg & modulus_mask) == modulus_mask);
    wire overflow = step && at_top;
    reg [7:0] wrap_value;
    reg [7:0] next_count;

    // Autoload only applies with PWM off; otherwise a wrap restarts at zero.
    always @* begin
        wrap_value = 8'h00;
        if (autoload_select && !pwm_out_select) begin
            wrap_value = reload_value_reg;
        end
    end

    // A software write and a tick in the same cycle: the write wins and the tick is lost.
    always @* begin
        next_count = count_value_reg;
        if (wr_count) begin
            next_count = pwdata[7:0];
        end else if (overflow) begin
            next_count = wrap_value;
        end else if (step) begin
            next_count = count_value_reg + 8'h01;
        end
    end

    // Leaving 0xFF by a wrap or a write raises the flag, as does every wrap in PWM mode.
    wire flag_set = ((count_value_reg == 8'hff) && (next_count != 8'hff)) ||
        (pwm_mode && overflow);

    // ****************************************************************
    // Mode, reload and mask registers
    // ****************************************************************
    always @(posedge mclk) begin
        if (!reset_n) begin
            timer_mode_reg <= `TRB_MODE_RST;
        end else if (wr_mode) begin
            timer_mode_reg <= pwdata[7:0];
        end
    end

    // There is no read-back, so software must always write the whole byte.
    always @(posedge mclk) begin
        if (!reset_n) begin
            reload_value_reg <= `TRB_RELOAD_RST;
        end else if (wr_reload) begin
            reload_value_reg <= pwdata[7:0];
        end
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            overflow_irq_enable <= `TRB_MASK_RST;
        end else if (wr_mask) begin
            overflow_irq_enable <= pwdata[0];
        end
    end

    // ****************************************************************
    // Count register
    // ****************************************************************
    always @(posedge mclk) begin
        if (!reset_n) begin
            count_value_reg <= `TRB_COUNT_RST;
        end else begin
            count_value_reg <= next_count;
        end
    end

    // ****************************************************************
    // Overflow flag
    // ****************************************************************
    // A new overflow wins over a clear in the same cycle, so no event is lost.
    always @(posedge mclk) begin
        if (!reset_n) begin
            overflow_irq_flag <= 1'b0;
        end else if (flag_set) begin
            overflow_irq_flag <= 1'b1;
        end else if (wr_stat && pwdata[0]) begin
            overflow_irq_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt output
    // ****************************************************************
    assign irq = overflow_irq_flag && overflow_irq_enable;

    // ****************************************************************
    // Buzzer toggle
    // ****************************************************************
    // The toggle restarts low on every start, so the first half period is full length.
    always @(posedge mclk) begin
        if (!reset_n) begin
            toggle_state <= 1'b0;
        end else if (!counter_run) begin
            toggle_state <= 1'b0;
        end else if (overflow && toggle_out_select && !pwm_out_select) begin
            toggle_state <= !toggle_state;
        end
    end

    // ****************************************************************
    // Output pin
    // ****************************************************************
    // Toggle is ignored while PWM is selected, so PWM takes precedence.
    assign shared_output_pin_oe = pwm_out_select || toggle_out_select;

    // The compare uses the count that the pin stands beside, so register changes show at
    // once; a reload written in mid-period can therefore give one malformed cycle.
    wire pwm_level = (next_count < reload_value_reg);
    reg next_pin;

    always @* begin
        next_pin = 1'b0;
        if (counter_run) begin
            if (pwm_out_select) begin
                if (overflow) begin
                    next_pin = 1'b1;
                end else begin
                    next_pin = pwm_level;
                end
            end else begin
                next_pin = toggle_state;
            end
        end
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            shared_output_pin <= 1'b0;
        end else begin
            shared_output_pin <= next_pin;
        end
    end
endmodule

/* core/trb_regs.vh */
// Register offsets, field positions, reset values and timing counts of the reload timer.
`ifndef TRB_REGS_VH
`define TRB_REGS_VH
// ********************************************************************
// Register locations
// ********************************************************************
// Mode, count and reload are word indices: the byte address is four times the index.
`define TRB_MODE_OFS 12'h0dc
`define TRB_COUNT_OFS 12'h0dd
`define TRB_RELOAD_OFS 12'h0de
// Status and mask are byte addresses, clear of the indexed words.
`define TRB_IRQ_STAT_OFS 12'h0e0
`define TRB_IRQ_MASK_OFS 12'h0e4
// ********************************************************************
// Mode register fields
// ********************************************************************
`define TRB_PWM_BIT 0
`define TRB_TOGGLE_BIT 1
`define TRB_ALOAD_BIT 2
`define TRB_CKS_BIT 3
`define TRB_RATE_LSB 4
`define TRB_RATE_MSB 6
`define TRB_RUN_BIT 7
// ********************************************************************
// Reset values and timing
// ********************************************************************
`define TRB_MODE_RST 8'h00
`define TRB_COUNT_RST 8'h00
`define TRB_RELOAD_RST 8'h00
`define TRB_MASK_RST 1'b0
`define TRB_PRESCALE_MAX 8'hff
`endif

/* core/trb_prescaler.v */
// Prescaler that turns the CPU cycle clock into a one-cycle tick enable.
`timescale 1ns/1ps
module trb_prescaler (
    input wire mclk,
    input wire reset_n,
    input wire run,
    input wire [2:0] rate,
    output reg tick
);
    reg [7:0] div_count;
    wire [7:0] next_div_count;
    reg [7:0] tap_mask;

    // Code 000 divides by 256, each higher code halves the period.
    always @* begin
        tap_mask = 8'hff >> rate;
    end

    assign next_div_count = div_count + 8'h01;

    always @(posedge mclk) begin
        if (!reset_n || !run) begin
            div_count <= 8'h00;
            tick <= 1'b0;
        end else begin
            div_count <= next_div_count;
            tick <= ((div_count & tap_mask) == tap_mask);
        end
    end
endmodule

/* sim/trb_tb_map.svh */
// Bus addresses of the timer registers: printed offsets are word indices.
`ifndef TRB_TB_MAP_SVH
`define TRB_TB_MAP_SVH
`define TRB_A_MODE (12'h0dc << 2)
`define TRB_A_COUNT (12'h0dd << 2)
`define TRB_A_RELOAD (12'h0de << 2)
`endif

/* sim/trb_timer_assertions.sv */
// Port-level checker for the reload timer.
`timescale 1ns/1ps
`include "trb_regs.vh"
`include "trb_tb_map.svh"
module trb_timer_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_event_irq_block,
    input wire logic shared_output_pin,
    input wire logic shared_output_pin_oe,
    input wire logic irq
);
    logic [7:0] mode_sh;
    logic mask_sh;
    logic mapped;
    assign mapped = paddr == `TRB_A_MODE || paddr == `TRB_A_COUNT || paddr == `TRB_A_RELOAD
        || paddr == `TRB_IRQ_STAT_OFS || paddr == `TRB_IRQ_MASK_OFS;
    // Software's view of mode and mask, the causes that the outputs are tied to.
    always @(posedge mclk) begin
        if (!reset_n) begin
            mode_sh <= 8'h00;
            mask_sh <= 1'b0;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == `TRB_A_MODE) mode_sh <= pwdata[7:0];
            if (paddr == `TRB_IRQ_MASK_OFS) mask_sh <= pwdata[0];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence s_rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong");
    a_reload_reads0: assert property (s_rd_setup(`TRB_A_RELOAD) |=> prdata == 32'h0)
        else $error("reload register readable");
    a_oe_pwm: assert property (mode_sh[0] |-> shared_output_pin_oe)
        else $error("pin not taken by pwm");
    a_oe_toggle: assert property (shared_output_pin_oe == (mode_sh[0] || mode_sh[1]))
        else $error("pin enable wrong");
    a_event_block: assert property (ext_event_irq_block == mode_sh[3])
        else $error("event irq block wrong");
    a_stop_pin: assert property (!mode_sh[7] && !$past(mode_sh[7]) |-> !shared_output_pin)
        else $error("pin active while stopped");
    a_irq_masked: assert property (irq |-> mask_sh) else $error("irq while masked");
    a_toggle_slow: assert property ($changed(shared_output_pin) && mode_sh[1] && !mode_sh[0]
        && $stable(mode_sh) |=> (!mode_sh[7] || $stable(shared_output_pin))[*3])
        else $error("toggle faster than overflow");
endmodule
bind trb_timer trb_timer_chk u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_event_irq_block(ext_event_irq_block),
    .shared_output_pin(shared_output_pin), .shared_output_pin_oe(shared_output_pin_oe),
    .irq(irq));

/* sim/trb_load.sv */
// Load on the shared output pin that measures high time and period.
`timescale 1ns/1ps
module trb_load (
    input wire logic mclk,
    input wire logic pin,
    input wire logic oe,
    output int hi_len,
    output int per
);
    logic lv;
    logic lv_q = 1'b0;
    int hc = 0;
    int pc = 0;
    int hi_q = 0;
    int per_q = 0;
    // The load pulls an undriven line low, so a released pin reads idle.
    assign lv = oe ? pin : 1'b0;
    assign hi_len = hi_q;
    assign per = per_q;
    always @(posedge mclk) begin
        lv_q <= lv;
        pc <= pc + 1;
        if (lv) hc <= hc + 1;
        if (lv && !lv_q) begin
            per_q <= pc;
            pc <= 1;
            hc <= 1;
        end
        if (!lv && lv_q) hi_q <= hc;
    end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the reload timer driving its load.
`timescale 1ns/1ps
`include "trb_regs.vh"
`include "trb_tb_map.svh"
module testbench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ext_event_input = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, blk, pin, oe, irq;
    logic [31:0] seed = 32'h9;
    logic [31:0] exp_q[$];
    int n_fail = 0;
    int n_compared = 0;
    int hi_len, per, md, rl;
    always #12.5 mclk = ~mclk;
    trb_timer u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_event_input(ext_event_input), .ext_event_irq_block(blk),
        .shared_output_pin(pin), .shared_output_pin_oe(oe), .irq(irq));
    trb_load u_load (.mclk(mclk), .pin(pin), .oe(oe), .hi_len(hi_len), .per(per));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // For a read, d is the expected data; it is noted when the request starts.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task summarize;
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            check("read data", prdata, exp_q.pop_front());
    end
    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        summarize;
    end
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        apb(0, `TRB_A_COUNT, 0);
        apb(0, `TRB_A_RELOAD, 0);
        apb(0, 12'hff0, 0);
        apb(1, `TRB_IRQ_MASK_OFS, 1);
        apb(1, `TRB_A_RELOAD, 8'h80);
        apb(1, `TRB_A_COUNT, 8'hfe);
        apb(1, `TRB_A_MODE, 8'h84);
        while (irq !== 1'b1) @(posedge mclk);
        apb(0, `TRB_A_COUNT, 8'h80);
        apb(0, `TRB_IRQ_STAT_OFS, 1);
        apb(1, `TRB_IRQ_MASK_OFS, 0);
        apb(1, `TRB_A_MODE, 0);
        apb(1, `TRB_A_COUNT, 8'hff);
        apb(1, `TRB_IRQ_STAT_OFS, 1);
        apb(0, `TRB_IRQ_STAT_OFS, 0);
        apb(1, `TRB_A_COUNT, 0);
        apb(0, `TRB_IRQ_STAT_OFS, 1);
        apb(0, `TRB_A_COUNT, 0);
        for (int r = 0; r < 8; r++) begin
            apb(1, `TRB_A_RELOAD, 8'hfe);
            apb(1, `TRB_A_COUNT, 8'hfe);
            apb(1, `TRB_A_MODE, 8'h86 | (r << 4));
            repeat (10 * (256 >> r)) @(posedge mclk);
            check("toggle high time", hi_len, 2 * (256 >> r));
            apb(1, `TRB_A_MODE, 0);
        end
        for (int m = 0; m < 4; m++) begin
            md = (m == 0) ? 256 : (128 >> m);
            seed = xs(seed);
            rl = 1 + seed % (md - 1);
            apb(1, `TRB_A_COUNT, 0);
            apb(1, `TRB_A_RELOAD, rl);
            apb(1, `TRB_IRQ_STAT_OFS, 1);
            apb(1, `TRB_A_MODE, 8'hf1 | (m << 1));
            repeat (6 * md + 8) @(posedge mclk);
            check("pwm high time", hi_len, 2 * rl);
            check("pwm period", per, 2 * md);
            apb(0, `TRB_IRQ_STAT_OFS, 1);
            apb(1, `TRB_A_MODE, 0);
        end
        apb(1, `TRB_A_COUNT, 8'hfe);
        apb(1, `TRB_IRQ_STAT_OFS, 1);
        apb(1, `TRB_A_MODE, 8'h88);
        repeat (2) begin
            seed = xs(seed);
            ext_event_input <= 1'b0;
            repeat (3 + seed[2:0]) @(posedge mclk);
            ext_event_input <= 1'b1;
            repeat (3 + seed[5:3]) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
        apb(0, `TRB_A_COUNT, 0);
        apb(0, `TRB_IRQ_STAT_OFS, 1);
        summarize;
    end
endmodule
